// ===== logic/seq_divider.sv
module seq_divider #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] dividend_i,
  input  wire logic [WIDTH-1:0] divisor_i,
  output logic                  done_o,
  output logic [WIDTH-1:0]      quotient_o
);

  logic [WIDTH-1:0]         rem;
  logic [WIDTH-1:0]         quo;
  logic [WIDTH-1:0]         dvs;
  logic [$clog2(WIDTH):0]   cnt;
  logic                     busy;

  wire logic [WIDTH:0] shifted = {rem, quo[WIDTH-1]};
  wire logic [WIDTH:0] trial   = shifted - {1'b0, dvs};
  wire logic           fits    = ~trial[WIDTH];

  // One quotient bit per clock: restoring division keeps area small
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rem    <= '0;
      quo    <= '0;
      dvs    <= '0;
      cnt    <= '0;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy) begin
        rem  <= '0;
        quo  <= dividend_i;
        dvs  <= divisor_i;
        cnt  <= ($clog2(WIDTH)+1)'(WIDTH);
        busy <= 1'b1;
      end else if (busy) begin
        rem  <= fits ? trial[WIDTH-1:0] : shifted[WIDTH-1:0];
        quo  <= {quo[WIDTH-2:0], fits};
        cnt  <= cnt - 1'b1;
        if (cnt == ($clog2(WIDTH)+1)'(1)) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  assign quotient_o = quo;

endmodule // seq_divider

// ===== logic/stepped_sweep_timing_control.sv
//Operation
//- Primary sweep stepping: uniform default, or logarithmic
//- Uniform: fixed increment from start to stop
//- Uniform step set by increment or point count
//- Logarithmic growth; step count from points only
//- Per-sweep duration 30 ms..99 s, primary 30
//- Writing a duration turns its auto off
//- Hold, span, increment, points may invalidate duration; span writes leave the check unchanged
//- Duration floor 2 ms..98.998 s, default 2
//- No sweep shorter than floor, auto included
//- Floor written for either sweep sets both
//- Auto computes duration from span width
//- Reset and preset switch auto duration on
//- Points = span / increment + 1, coupled
//- Increment ignored while logarithmic stepping
module stepped_sweep_timing_control
  import sweep_timing_pkg::*;
#(
  parameter logic [31:0] SPAN_RST    = 32'h0098_9680,
  parameter logic [16:0] DUR_SEC_RST = 17'h0001E,
  parameter logic [16:0] HOLD_RST    = 17'h00001
) (
  input  wire logic          CORE_CLK_I,
  input  wire logic          RST_N_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [7:0]    PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic [31:0]        PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  input  wire logic          STEP_ADV_I,
  output logic [31:0]        FREQ_O,
  output logic               SWEEP_ACTIVE_O,
  output logic               STEP_LOG_O,
  output sweep_timing_s      PRIM_TIMING_O,
  output sweep_timing_s      SEC_TIMING_O
);

  logic          step_log;
  logic          auto_p;
  logic          auto_s;
  logic [16:0]   dur_p;
  logic [16:0]   dur_s;
  logic [16:0]   floor_ms;
  logic [16:0]   hold_ms;
  logic [31:0]   span;
  logic [31:0]   incr;
  logic [31:0]   points;
  logic [31:0]   start_freq;
  logic [31:0]   cur_freq;
  logic [31:0]   step_idx;
  logic          running;
  logic          reject;
  couple_state_e cstate;
  logic          div_done;
  logic [31:0]   quotient;

  function automatic logic [16:0] max_ms(input logic [16:0] a, input logic [16:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic in_range(input logic [31:0] v, input logic [16:0] lo, input logic [16:0] hi);
    return (v >= {15'h0000, lo}) && (v <= {15'h0000, hi});
  endfunction

  // Time grows with span; saturates at the longest legal duration
  function automatic logic [16:0] auto_duration(input logic [31:0] s);
    logic [31:0] t;
    t = {15'h0000, AUTO_BASE_MS} + (s >> AUTO_SHIFT);
    return (t > {15'h0000, DUR_MAX_MS}) ? DUR_MAX_MS : t[16:0];
  endfunction

  // APB decode
  wire logic wr_acc   = PSEL_I & PENABLE_I & PWRITE_I;
  wire logic hit_ctrl = PADDR_I == OFS_CTRL;
  wire logic hit_durp = PADDR_I == OFS_DUR_PRIM;
  wire logic hit_durs = PADDR_I == OFS_DUR_SEC;
  wire logic hit_flr  = (PADDR_I == OFS_FLOOR_PRI) | (PADDR_I == OFS_FLOOR_SEC);
  wire logic hit_span = PADDR_I == OFS_SPAN;
  wire logic hit_incr = PADDR_I == OFS_INCREMENT;
  wire logic hit_pts  = PADDR_I == OFS_POINTS;
  wire logic hit_hold = PADDR_I == OFS_HOLD;
  wire logic hit_stat = PADDR_I == OFS_STATUS;
  wire logic hit_strt = PADDR_I == OFS_START_FRQ;
  wire logic hit_effp = PADDR_I == OFS_EFF_PRIM;
  wire logic hit_effs = PADDR_I == OFS_EFF_SEC;
  wire logic hit_fnow = PADDR_I == OFS_FREQ_NOW;
  // Effective durations and the live frequency are views, so writes to them are refused
  wire logic hit_ro   = hit_effp | hit_effs | hit_fnow;
  wire logic mapped   = hit_ctrl | hit_durp | hit_durs | hit_flr | hit_span | hit_incr | hit_pts
                        | hit_hold | hit_stat | hit_strt | hit_ro;

  // Write validity checks
  wire logic dur_ok   = in_range(PWDATA_I, DUR_MIN_MS, DUR_MAX_MS);
  wire logic flr_ok   = in_range(PWDATA_I, FLOOR_MIN_MS, FLOOR_MAX_MS);
  // Log stepping takes its count from points only, so increment writes drop silently
  wire logic incr_ign = hit_incr & step_log;
  wire logic incr_ok  = (PWDATA_I != 32'h0000_0000) && (PWDATA_I <= span);
  wire logic pts_ok   = (PWDATA_I >= POINTS_MIN) && (PWDATA_I <= POINTS_MAX);
  // Hold must fit the millisecond field; zero would make every duration look valid
  wire logic hold_ok  = (PWDATA_I[31:17] == 15'h0000) && (PWDATA_I[16:0] != 17'h00000);
  wire logic bad_dur  = (hit_durp | hit_durs) & ~dur_ok;
  wire logic bad_flr  = hit_flr & ~flr_ok;
  wire logic bad_cpl  = (hit_incr & ~incr_ign & ~incr_ok) | (hit_pts & ~pts_ok);
  wire logic bad_wr   = ~mapped | bad_dur | bad_flr | bad_cpl
                        | (hit_hold & ~hold_ok) | (hit_ro & PWRITE_I);
  wire logic bad_rd   = ~mapped;
  wire logic need_div = wr_acc & ~bad_wr & ((hit_incr & ~incr_ign) | hit_pts);

  // Coupled writes stall the bus until the divider has finished
  wire logic div_start = need_div & (cstate == ST_IDLE);
  // P points split the span into P-1 intervals
  wire logic [31:0] divisor = hit_pts ? (PWDATA_I - 32'h0000_0001) : PWDATA_I;

  seq_divider #(.WIDTH(32)) u_div (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (RST_N_I),
    .start_i    (div_start),
    .dividend_i (span),
    .divisor_i  (divisor),
    .done_o     (div_done),
    .quotient_o (quotient)
  );

  // Ready stays low only while a coupled write waits for its quotient
  assign PREADY_O  = ~need_div | (cstate == ST_DONE);
  assign PSLVERR_O = PSEL_I & PENABLE_I & (PWRITE_I ? bad_wr : bad_rd);

  wire logic commit = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & ~bad_wr;
  // Preset stands in for the reset command: auto timing returns, log bit taken from the write, other settings stay
  wire logic preset = commit & hit_ctrl & PWDATA_I[CTRL_PRESET];

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      cstate <= ST_IDLE;
    end else begin
      case (cstate)
        ST_IDLE: cstate <= div_start ? ST_DIV : ST_IDLE;
        ST_DIV:  cstate <= div_done ? ST_DONE : ST_DIV;
        // Quotient is stable in ST_DONE, the cycle in which the write commits
        ST_DONE: cstate <= ST_IDLE;
        default: cstate <= ST_IDLE;
      endcase
    end
  end

  // Effective durations: chosen value raised to the shared floor
  wire logic [16:0] auto_dur  = auto_duration(span);
  wire logic [16:0] sel_p     = auto_p ? auto_dur : dur_p;
  wire logic [16:0] sel_s     = auto_s ? auto_dur : dur_s;
  wire logic [16:0] eff_p     = max_ms(sel_p, floor_ms);
  wire logic [16:0] eff_s     = max_ms(sel_s, floor_ms);

  // With auto off, hold times point count exceeding the stored duration flags it invalid
  wire logic [30:0] need_ms   = 31'(hold_ms) * 31'(points[13:0]);
  wire logic        inv_p     = ~auto_p & (need_ms > {14'h0000, dur_p});
  wire logic        inv_s     = ~auto_s & (need_ms > {14'h0000, dur_s});

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      step_log   <= 1'b0;
      auto_p     <= 1'b1;
      auto_s     <= 1'b1;
      dur_p      <= DUR_PRIM_RST_MS;
      dur_s      <= DUR_SEC_RST;
      floor_ms   <= FLOOR_RST_MS;
      hold_ms    <= HOLD_RST;
      span       <= SPAN_RST;
      points     <= POINTS_RST;
      incr       <= SPAN_RST / (POINTS_RST - 32'h0000_0001);
      start_freq <= 32'h0000_0000;
    end else if (preset) begin
      step_log <= PWDATA_I[CTRL_LOG];
      auto_p   <= 1'b1;
      auto_s   <= 1'b1;
    end else if (commit) begin
      if (hit_ctrl) begin
        step_log <= PWDATA_I[CTRL_LOG];
        auto_p   <= PWDATA_I[CTRL_AUTO_P];
        auto_s   <= PWDATA_I[CTRL_AUTO_S];
      end
      if (hit_durp) begin
        dur_p  <= PWDATA_I[16:0];
        auto_p <= 1'b0;
      end
      if (hit_durs) begin
        dur_s  <= PWDATA_I[16:0];
        auto_s <= 1'b0;
      end
      if (hit_flr) begin
        floor_ms <= PWDATA_I[16:0];
      end
      if (hit_hold) begin
        hold_ms <= PWDATA_I[16:0];
      end
      if (hit_span) begin
        span <= PWDATA_I;
      end
      if (hit_strt) begin
        start_freq <= PWDATA_I;
      end
      if (hit_pts) begin
        points <= PWDATA_I;
        incr   <= quotient;
      end
      if (hit_incr && !incr_ign) begin
        incr   <= PWDATA_I;
        points <= quotient + 32'h0000_0001;
      end
    end
  end

  // Stepper: one step per advance pulse while a sweep runs
  wire logic [32:0] stop_freq = {1'b0, start_freq} + {1'b0, span};
  wire logic [31:0] log_step  = (cur_freq >> LOG_SHIFT) | 32'h0000_0001;
  wire logic [31:0] step_size = step_log ? log_step : incr;
  wire logic [32:0] next_freq = {1'b0, cur_freq} + {1'b0, step_size};
  wire logic        last_step = (next_freq >= stop_freq)
                                | (step_idx >= points - 32'h0000_0002);
  wire logic        run_req   = commit & hit_ctrl & PWDATA_I[CTRL_RUN];
  wire logic        step_now  = running & STEP_ADV_I;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      cur_freq <= 32'h0000_0000;
      step_idx <= 32'h0000_0000;
      running  <= 1'b0;
    end else if (run_req) begin
      cur_freq <= start_freq;
      step_idx <= 32'h0000_0000;
      running  <= 1'b1;
    end else if (step_now) begin
      step_idx <= step_idx + 32'h0000_0001;
      // Clamp to stop so a rounded-down increment never leaves the span short
      if (last_step) begin
        cur_freq <= stop_freq[31:0];
        running  <= 1'b0;
      end else begin
        cur_freq <= next_freq[31:0];
      end
    end
  end

  // Rejected writes stay flagged until software clears; a new reject wins
  wire logic rej_set = PSEL_I & PENABLE_I & PWRITE_I & bad_wr;
  wire logic rej_clr = commit & hit_stat & PWDATA_I[STAT_REJECT];

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      reject <= 1'b0;
    end else if (rej_set) begin
      reject <= 1'b1;
    end else if (rej_clr) begin
      reject <= 1'b0;
    end
  end

  // Timing snapshot per sweep, registered with the other outputs
  wire sweep_timing_s next_prim_timing = '{auto_on: auto_p, duration: dur_p, effective: eff_p};
  wire sweep_timing_s next_sec_timing  = '{auto_on: auto_s, duration: dur_s, effective: eff_s};

  wire logic [31:0] ctrl_rd = {27'h0000000, running, 1'b0, auto_s, auto_p, step_log};
  wire logic [31:0] stat_rd = {28'h0000000, running, reject, inv_s, inv_p};
  wire logic [31:0] rd_mux  =
      hit_ctrl ? ctrl_rd :
      hit_durp ? {15'h0000, dur_p} :
      hit_durs ? {15'h0000, dur_s} :
      hit_flr  ? {15'h0000, floor_ms} :
      hit_span ? span :
      hit_incr ? incr :
      hit_pts  ? points :
      hit_hold ? {15'h0000, hold_ms} :
      hit_effp ? {15'h0000, eff_p} :
      hit_effs ? {15'h0000, eff_s} :
      hit_stat ? stat_rd :
      hit_strt ? start_freq :
      hit_fnow ? cur_freq : 32'h0000_0000;

  // Read data registered during the setup phase so it is stable in access
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      PRDATA_O       <= 32'h0000_0000;
      FREQ_O         <= 32'h0000_0000;
      SWEEP_ACTIVE_O <= 1'b0;
      STEP_LOG_O     <= 1'b0;
      PRIM_TIMING_O  <= '0;
      SEC_TIMING_O   <= '0;
    end else begin
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        PRDATA_O <= rd_mux;
      end
      FREQ_O         <= cur_freq;
      SWEEP_ACTIVE_O <= running;
      STEP_LOG_O     <= step_log;
      PRIM_TIMING_O  <= next_prim_timing;
      SEC_TIMING_O   <= next_sec_timing;
    end
  end

endmodule // stepped_sweep_timing_control

// ===== logic/sweep_timing_pkg.sv
package sweep_timing_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DUR_PRIM  = 8'h04;
  localparam logic [7:0] OFS_DUR_SEC   = 8'h08;
  localparam logic [7:0] OFS_FLOOR_PRI = 8'h0C;
  localparam logic [7:0] OFS_FLOOR_SEC = 8'h10;
  localparam logic [7:0] OFS_SPAN      = 8'h14;
  localparam logic [7:0] OFS_INCREMENT = 8'h18;
  localparam logic [7:0] OFS_POINTS    = 8'h1C;
  localparam logic [7:0] OFS_HOLD      = 8'h20;
  localparam logic [7:0] OFS_EFF_PRIM  = 8'h24;
  localparam logic [7:0] OFS_EFF_SEC   = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h2C;
  localparam logic [7:0] OFS_START_FRQ = 8'h30;
  localparam logic [7:0] OFS_FREQ_NOW  = 8'h34;

  // Control register fields
  localparam int CTRL_LOG    = 0;
  localparam int CTRL_AUTO_P = 1;
  localparam int CTRL_AUTO_S = 2;
  localparam int CTRL_PRESET = 3;
  localparam int CTRL_RUN    = 4;

  // Status register fields
  localparam int STAT_INV_P  = 0;
  localparam int STAT_INV_S  = 1;
  localparam int STAT_REJECT = 2;
  localparam int STAT_ACTIVE = 3;

  // Durations are held in whole milliseconds
  localparam logic [16:0] DUR_MIN_MS      = 17'h0001E;  // 30 ms
  localparam logic [16:0] DUR_MAX_MS      = 17'h182B8;  // 99 s
  localparam logic [16:0] FLOOR_MIN_MS    = 17'h00002;  // 2 ms
  localparam logic [16:0] FLOOR_MAX_MS    = 17'h182B6;  // 98.998 s
  localparam logic [16:0] DUR_PRIM_RST_MS = 17'h0001E;  // 30 ms
  localparam logic [16:0] FLOOR_RST_MS    = 17'h00002;  // 2 ms

  // Point count limits and reset value
  localparam logic [31:0] POINTS_MIN = 32'h0000_0002;
  localparam logic [31:0] POINTS_MAX = 32'h0000_2711;  // 10001
  localparam logic [31:0] POINTS_RST = 32'h0000_2711;

  // Automatic duration: base plus span scaled down by a shift
  localparam logic [16:0] AUTO_BASE_MS = 17'h0001E;
  localparam int          AUTO_SHIFT   = 20;
  localparam int          LOG_SHIFT    = 6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b10
  } couple_state_e;

  typedef struct packed {
    logic        auto_on;
    logic [16:0] duration;
    logic [16:0] effective;
  } sweep_timing_s;

endpackage

// ===== tb/apb_host.sv
module apb_host (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  output logic             done_o,
  output logic [31:0]      rdata_o,
  output logic             err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {psel_o, penable_o, pwrite_o, done_o, err_o} = 5'h0;
    paddr_o  = 8'hFF;
    pwdata_o = 32'hFFFF_FFFF;
    rdata_o  = 32'h0;
  end
  // Request stands until pready is seen high at a rising edge; the answer is taken there
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    @(posedge clk_i);
    psel_o    <= 1'b1;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    r = prdata_i;
    e = pslverr_i;
    {psel_o, penable_o} <= 2'h0;
    paddr_o  <= ~a;
    pwdata_o <= ~d;
    rdata_o  <= r;
    err_o    <= e;
    done_o   <= 1'b1;
    @(posedge clk_i);
    done_o   <= 1'b0;
  endtask
endmodule // apb_host

// ===== tb/stepped_sweep_timing_control_test.sv
module stepped_sweep_timing_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sweep_timing_pkg::*;
  localparam logic [31:0] span = 32'h0098_9680;
  logic clk, rst_n, psel, pen, pwr, pready, perr, stp, done, err, act;
  logic [7:0]  paddr, a;
  logic [31:0] pwd, prd, rdata, v, seed, freq;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int          n_fail, comparisons, i;

  apb_host u_apb_host (.clk_i(clk), .prdata_i(prd), .pready_i(pready), .pslverr_i(perr), .psel_o(psel),
    .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd), .done_o(done), .rdata_o(rdata), .err_o(err));
  stepped_sweep_timing_control #(.SPAN_RST(span)) u_stepped_sweep_timing_control (.CORE_CLK_I(clk),
    .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr), .STEP_ADV_I(stp), .FREQ_O(freq), .SWEEP_ACTIVE_O(act),
    .STEP_LOG_O(), .PRIM_TIMING_O(), .SEC_TIMING_O());

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] x);
    comparisons++;
    if (seen !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, x, seen);
    end
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("result count", 32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        check("pslverr", {31'h0, err}, {31'h0, e[32]});
        if (e[33]) begin
          check("prdata", rdata, e[31:0]);
        end
      end
    end
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic x);
    exp_q.push_back({1'b0, x, 32'h0});
    u_apb_host.xfer(1'b1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic x);
    exp_q.push_back({~x, x, d});
    u_apb_host.xfer(1'b0, ad, 32'h0);
  endtask
  task automatic pulse();
    @(posedge clk);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic chk_rst();
    rd(OFS_CTRL, 32'h6, 1'b0);
    rd(OFS_DUR_PRIM, 32'(DUR_PRIM_RST_MS), 1'b0);
    rd(OFS_FLOOR_SEC, 32'(FLOOR_RST_MS), 1'b0);
    rd(OFS_EFF_PRIM, 32'h1E + (span >> 20), 1'b0);
    rd(OFS_POINTS, POINTS_RST, 1'b0);
    $display("test reset values done");
  endtask
  task automatic finish_test();
    check("pending results", 32'(exp_q.size()), 32'h0);
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  initial begin
    {rst_n, stp} = 2'h0;
    n_fail = 0;
    comparisons = 0;
    seed = $urandom(41);
    do_reset();
    chk_rst();
    for (i = 0; i < 2; i++) begin
      a = i ? OFS_DUR_SEC : OFS_DUR_PRIM;
      wr(a, 32'(DUR_MIN_MS) - 32'h1, 1'b1);
      wr(a, 32'(DUR_MAX_MS) + 32'h1, 1'b1);
      rd(a, 32'(DUR_MIN_MS), 1'b0);
      wr(a, 32'(DUR_MAX_MS), 1'b0);
      rd(a, 32'(DUR_MAX_MS), 1'b0);
      v = 32'(DUR_MIN_MS) + $urandom % 32'h1829B;
      wr(a, v, 1'b0);
      rd(a + 8'h20, v, 1'b0);
    end
    rd(OFS_CTRL, 32'h0, 1'b0);
    rd(8'h38, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(OFS_EFF_SEC, 32'h0, 1'b1);
    $display("test durations done");
    wr(OFS_CTRL, 32'h6, 1'b0);
    wr(OFS_FLOOR_SEC, 32'(FLOOR_MAX_MS), 1'b0);
    rd(OFS_FLOOR_PRI, 32'(FLOOR_MAX_MS), 1'b0);
    rd(OFS_EFF_PRIM, 32'(FLOOR_MAX_MS), 1'b0);
    wr(OFS_FLOOR_PRI, 32'h32, 1'b0);
    rd(OFS_EFF_SEC, 32'h32, 1'b0);
    wr(OFS_FLOOR_PRI, 32'(FLOOR_MIN_MS) - 32'h1, 1'b1);
    wr(OFS_FLOOR_SEC, 32'(FLOOR_MAX_MS) + 32'h1, 1'b1);
    rd(OFS_FLOOR_SEC, 32'h32, 1'b0);
    $display("test floor done");
    wr(OFS_POINTS, 32'hB, 1'b0);
    rd(OFS_INCREMENT, span / 32'hA, 1'b0);
    wr(OFS_INCREMENT, 32'h2D_C6C0, 1'b0);
    rd(OFS_POINTS, span / 32'h2D_C6C0 + 32'h1, 1'b0);
    rd(OFS_SPAN, span, 1'b0);
    v = POINTS_MIN + $urandom % 32'h2710;
    wr(OFS_POINTS, v, 1'b0);
    rd(OFS_INCREMENT, span / (v - 32'h1), 1'b0);
    wr(OFS_INCREMENT, 32'h0, 1'b1);
    wr(OFS_INCREMENT, span + 32'h1, 1'b1);
    wr(OFS_POINTS, POINTS_MIN - 32'h1, 1'b1);
    wr(OFS_POINTS, POINTS_MAX + 32'h1, 1'b1);
    rd(OFS_POINTS, v, 1'b0);
    $display("test coupling done");
    wr(OFS_DUR_PRIM, 32'h64, 1'b0);
    wr(OFS_POINTS, 32'h4, 1'b0);
    wr(OFS_HOLD, 32'h32, 1'b0);
    rd(OFS_STATUS, 32'h5, 1'b0);
    wr(OFS_STATUS, 32'h4, 1'b0);
    rd(OFS_STATUS, 32'h1, 1'b0);
    wr(OFS_HOLD, 32'h19, 1'b0);
    rd(OFS_STATUS, 32'h0, 1'b0);
    $display("test invalid done");
    wr(OFS_START_FRQ, 32'h3E8, 1'b0);
    wr(OFS_CTRL, 32'h10, 1'b0);
    pulse();
    check("freq_o", freq, 32'h3E8 + span / 32'h3);
    check("sweep_active_o", {31'h0, act}, 32'h1);
    rd(OFS_FREQ_NOW, 32'h3E8 + span / 32'h3, 1'b0);
    rd(OFS_CTRL, 32'h10, 1'b0);
    pulse();
    pulse();
    check("freq_o", freq, 32'h3E8 + span);
    check("sweep_active_o", {31'h0, act}, 32'h0);
    rd(OFS_FREQ_NOW, 32'h3E8 + span, 1'b0);
    rd(OFS_CTRL, 32'h0, 1'b0);
    wr(OFS_CTRL, 32'h8, 1'b0);
    rd(OFS_CTRL, 32'h6, 1'b0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    wr(OFS_INCREMENT, 32'h5, 1'b0);
    rd(OFS_INCREMENT, span / 32'h3, 1'b0);
    wr(OFS_CTRL, 32'h11, 1'b0);
    pulse();
    rd(OFS_FREQ_NOW, 32'h3E8 + ((32'h3E8 >> LOG_SHIFT) | 32'h1), 1'b0);
    rd(OFS_CTRL, 32'h11, 1'b0);
    $display("test stepping done");
    @(posedge clk);
    do_reset();
    chk_rst();
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule // stepped_sweep_timing_control_test

// ===== tb/sweep_timing_assertions.sv
module sweep_timing_checker
  import sweep_timing_pkg::*;
(
  input wire logic          CORE_CLK_I,
  input wire logic          RST_N_I,
  input wire logic          PSEL_I,
  input wire logic          PENABLE_I,
  input wire logic          PWRITE_I,
  input wire logic [7:0]    PADDR_I,
  input wire logic [31:0]   PWDATA_I,
  input wire logic [31:0]   PRDATA_O,
  input wire logic          PREADY_O,
  input wire logic          PSLVERR_O,
  input wire logic          STEP_ADV_I,
  input wire logic [31:0]   FREQ_O,
  input wire logic          SWEEP_ACTIVE_O,
  input wire logic          STEP_LOG_O,
  input wire sweep_timing_s PRIM_TIMING_O,
  input wire sweep_timing_s SEC_TIMING_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [31:0] wd;
  wire         acc  = PSEL_I && PENABLE_I && PREADY_O;
  wire         wacc = acc && PWRITE_I;
  wire         wok  = wacc && !PSLVERR_O;
  wire         dur  = PADDR_I == OFS_DUR_PRIM || PADDR_I == OFS_DUR_SEC;
  wire         flr  = PADDR_I == OFS_FLOOR_PRI || PADDR_I == OFS_FLOOR_SEC;
  wire         ctl  = PADDR_I == OFS_CTRL;
  // Write data is held after acceptance, so later checks need no deep $past
  always_ff @(posedge CORE_CLK_I) begin
    if (acc) begin
      wd <= PWDATA_I;
    end
  end
  a_unmapped_refused: assert property (acc && (PADDR_I > OFS_FREQ_NOW || PADDR_I[1:0] != 2'h0) |-> PSLVERR_O)
    else $error("unmapped access accepted");
  a_dur_range: assert property (wacc && dur && (PWDATA_I < 32'(DUR_MIN_MS) || PWDATA_I > 32'(DUR_MAX_MS)) |-> PSLVERR_O)
    else $error("duration out of range accepted");
  a_floor_range: assert property (wacc && flr && (PWDATA_I < 32'(FLOOR_MIN_MS) || PWDATA_I > 32'(FLOOR_MAX_MS)) |-> PSLVERR_O)
    else $error("floor out of range accepted");
  a_dur_auto_off: assert property (wok && PADDR_I == OFS_DUR_PRIM |-> ##[1:2] (!PRIM_TIMING_O.auto_on && PRIM_TIMING_O.duration == wd[16:0]))
    else $error("duration write kept auto on");
  a_floor_both: assert property (wok && flr |-> ##[1:2] (PRIM_TIMING_O.effective >= wd[16:0] && SEC_TIMING_O.effective >= wd[16:0]))
    else $error("floor not applied to both sweeps");
  a_eff_over_dur: assert property ((!PRIM_TIMING_O.auto_on |-> PRIM_TIMING_O.effective >= PRIM_TIMING_O.duration) and (!SEC_TIMING_O.auto_on |-> SEC_TIMING_O.effective >= SEC_TIMING_O.duration))
    else $error("effective below duration");
  a_eff_min: assert property ($past(RST_N_I, 2) |-> PRIM_TIMING_O.effective >= DUR_MIN_MS && SEC_TIMING_O.effective >= DUR_MIN_MS)
    else $error("effective below minimum");
  a_log_follows: assert property (wok && ctl |-> ##[1:2] STEP_LOG_O == wd[CTRL_LOG])
    else $error("stepping mode not taken");
  a_preset_auto: assert property (wok && ctl && PWDATA_I[CTRL_PRESET] |-> ##[1:2] (PRIM_TIMING_O.auto_on && SEC_TIMING_O.auto_on))
    else $error("preset left auto off");
  a_log_incr_free: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_INCREMENT && STEP_LOG_O |-> PREADY_O && !PSLVERR_O)
    else $error("increment used in log mode");
  a_ready_bound: assert property (PSEL_I && PENABLE_I && !PREADY_O |-> ##[1:40] PREADY_O)
    else $error("wait state too long");
  c_points_write: cover property (wok && PADDR_I == OFS_POINTS);
  c_sweep_end: cover property ($fell(SWEEP_ACTIVE_O));
  c_refused: cover property (acc && PSLVERR_O);
endmodule // sweep_timing_checker

bind stepped_sweep_timing_control sweep_timing_checker u_sweep_timing_checker (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .STEP_ADV_I(STEP_ADV_I), .FREQ_O(FREQ_O), .SWEEP_ACTIVE_O(SWEEP_ACTIVE_O), .STEP_LOG_O(STEP_LOG_O),
  .PRIM_TIMING_O(PRIM_TIMING_O), .SEC_TIMING_O(SEC_TIMING_O));
